/* File: hw/adc_pkg.sv */
package adc_pkg;

	// ****************************************************************
	// timing, clock at 25 MHz
	// ****************************************************************
	localparam int CLK_MHZ     = 25;
	localparam int ACQ_MIN_NS  = 1500;
	localparam int ACQ_MAX_NS  = 6500;
	localparam int CONV12_NS   = 7300;
	localparam int CONV8_NS    = 3500;
	// least times round up, the longest acquisition rounds down
	localparam int ACQ_MIN_CYC = (ACQ_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int ACQ_MAX_CYC = (ACQ_MAX_NS * CLK_MHZ) / 1000;
	localparam int ACQ_SPAN    = ACQ_MAX_CYC - ACQ_MIN_CYC;
	localparam int ACQ_STEPS   = 15;
	localparam int CONV12_CYC  = (CONV12_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV8_CYC   = (CONV8_NS * CLK_MHZ + 999) / 1000;

	// ****************************************************************
	// register map (byte addresses, 7-bit bus address)
	// ****************************************************************
	localparam logic [6:0] CFG_OFS   = 7'h00;
	localparam logic [6:0] INTEN_OFS = 7'h08;
	localparam logic [6:0] STAT_OFS  = 7'h10;
	localparam logic [6:0] FIFO_OFS  = 7'h18;
	localparam logic [6:0] CNT_OFS   = 7'h20;
	localparam logic [6:0] COEF_OFS  = 7'h28;

	// configuration fields
	localparam int CFG_START = 0;
	localparam int CFG_RESET = 1;
	localparam int CFG_AZ    = 2;
	localparam int CFG_FULL  = 3;
	localparam int CFG_PTR   = 8;
	localparam int CFG_DIAG  = 11;
	localparam logic [1:0] PTR_NONE = 2'h3;

	// interrupt enable fields: mask [7:0], fifo threshold [13:8]
	localparam int INTEN_THR = 8;
	localparam logic [15:0] INTEN_RST = 16'h0000;

	// interrupt status bits
	localparam int INT_LIM1 = 0;
	localparam int INT_LIM2 = 1;
	localparam int INT_THR  = 2;
	localparam int INT_FULL = 3;
	localparam int INT_CAL  = 4;
	localparam int INT_PAUS = 5;
	localparam int INT_END  = 6;
	localparam int INT_OVF  = 7;

	// instruction section 0 fields, limit section fields
	localparam int INS_LOOP  = 0;
	localparam int INS_PAUSE = 1;
	localparam int INS_POS   = 2;
	localparam int INS_NEG   = 5;
	localparam int INS_RES8  = 10;
	localparam int INS_WDOG  = 11;
	localparam int INS_ACQ   = 12;
	localparam int LIM_GT    = 9;

	// sizes
	localparam int FIFO_DEPTH = 32;
	localparam int N_INS      = 8;
	localparam int N_CAP      = 13;
	localparam logic [2:0] CAL_LAST_REP = 3'h7;

	// calibration step table: [7:6] op, [3:0] capacitor
	localparam logic [1:0] OP_OFS = 2'h0;
	localparam logic [1:0] OP_CAP = 2'h1;
	localparam logic [1:0] OP_END = 2'h2;
	localparam logic [127:0] CAL_ROM =
		128'h80804c4b4a4948474645444342414000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_ACQ   = 3'b011,
		ST_CONV  = 3'b010,
		ST_CAL   = 3'b110,
		ST_CALW  = 3'b111
	} seq_state_e;

endpackage

/* File: hw/adc_sequencer_calibration_control.sv */
`timescale 1ns/1ns
module adc_sequencer_calibration_control (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [6:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        chip_select_n,
	input  wire logic        bus_width_select,
	input  wire logic [12:0] raw_result,
	input  wire logic [15:0] cal_error,
	input  wire logic        cal_error_valid,
	output logic             conv_start,
	output logic             conv_res8,
	output logic             sample_hold,
	output logic             cal_measure,
	output logic [3:0]       cal_cap,
	output logic [2:0]       mux_pos,
	output logic [2:0]       mux_neg,
	output logic             diag_route,
	output logic             int_n,
	output logic             transfer_request
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic cs_meta_q, cs_q, bw_meta_q, bw_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_meta_q <= 1'b1;
			cs_q      <= 1'b1;
			bw_meta_q <= 1'b0;
			bw_q      <= 1'b0;
		end else begin
			cs_meta_q <= chip_select_n;
			cs_q      <= cs_meta_q;
			bw_meta_q <= bus_width_select;
			bw_q      <= bw_meta_q;
		end
	end
	wire run = cs_q;

	// ****************************************************************
	// bus slave: one wait cycle, effects on the completing edge
	// ****************************************************************
	logic ack_q;
	assign waitrequest = (read | write) & ~ack_q;
	wire acc_wr = write & ack_q;
	wire acc_rd = read & ack_q;
	wire hi     = bw_q & address[2];
	wire [6:0] reg_sel = {address[6:3], 3'h0};
	wire ctrl_hit = ~address[6] & (bw_q | ~address[2]);
	logic [1:0] ptr_q;
	wire [2:0] iram_ins = bw_q ? address[5:3] : address[4:2];
	wire iram_hit = address[6] & (bw_q | ~address[5]) & (ptr_q != adc_pkg::PTR_NONE);
	wire [15:0] wdata16 = bw_q ? {writedata[7:0], writedata[7:0]} : writedata[15:0];
	wire [15:0] wmask = bw_q ? (hi ? 16'hff00 : 16'h00ff) : 16'hffff;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] wm);
		return (old & ~wm) | (wd & wm);
	endfunction

	always_ff @(posedge clock or posedge rst) begin
		if (rst) ack_q <= 1'b0;
		else ack_q <= (read | write) & ~ack_q;
	end

	// ****************************************************************
	// storage: instructions, coefficients, configuration
	// ****************************************************************
	logic [47:0] iram_q [adc_pkg::N_INS];
	logic [15:0] offset_coef_q;
	logic [15:0] lin_coef_q [adc_pkg::N_CAP];
	logic        start_q, az_q, fc_q, diag_q;
	logic [15:0] inten_q;
	logic [7:0]  stat_q;
	adc_pkg::seq_state_e state_q;
	logic [2:0]  pc_q;
	wire busy = (state_q != adc_pkg::ST_IDLE);
	wire [15:0] cfg_rd = {4'h0, diag_q, 1'b0, ptr_q, 4'h0, fc_q, az_q, 1'b0, start_q | busy};
	wire wr_cfg = acc_wr & ctrl_hit & (reg_sel == adc_pkg::CFG_OFS);
	// unwritten byte lanes keep the start bit itself, not the busy flag read back in bit 0
	wire [15:0] cfg_m = merge16({cfg_rd[15:1], start_q}, wdata16, wmask);
	wire soft_rst = wr_cfg & cfg_m[adc_pkg::CFG_RESET];
	wire [15:0] ins = iram_q[pc_q][15:0];
	wire [5:0] fifo_thr = inten_q[adc_pkg::INTEN_THR +: 6];

	// instruction sections are reachable at any time; the host keeps the
	// sequencer stopped around an access and soft resets after it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < adc_pkg::N_INS; i++) iram_q[i] <= 48'h0;
		end else if (acc_wr & iram_hit) begin
			iram_q[iram_ins][{ptr_q, 4'h0} +: 16] <=
				merge16(iram_q[iram_ins][{ptr_q, 4'h0} +: 16], wdata16, wmask);
		end
	end

	// configuration and interrupt enable writes
	logic pause_clr, cal_done;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
			az_q    <= 1'b0;
			fc_q    <= 1'b0;
			ptr_q   <= 2'h0;
			diag_q  <= 1'b0;
			inten_q <= adc_pkg::INTEN_RST;
		end else begin
			if (pause_clr) start_q <= 1'b0;
			if (cal_done) begin
				az_q <= 1'b0;
				fc_q <= 1'b0;
			end
			if (wr_cfg) begin
				start_q <= cfg_m[adc_pkg::CFG_START] & ~cfg_m[adc_pkg::CFG_RESET];
				az_q    <= cfg_m[adc_pkg::CFG_AZ] | (az_q & ~cal_done);
				fc_q    <= cfg_m[adc_pkg::CFG_FULL] | (fc_q & ~cal_done);
				ptr_q   <= cfg_m[adc_pkg::CFG_PTR +: 2];
				diag_q  <= cfg_m[adc_pkg::CFG_DIAG];
			end
			if (acc_wr & ctrl_hit & (reg_sel == adc_pkg::INTEN_OFS))
				inten_q <= merge16(inten_q, wdata16, wmask);
		end
	end
	assign diag_route = diag_q;

	// ****************************************************************
	// correction arithmetic and window compare
	// ****************************************************************
	wire ins_res8 = ins[adc_pkg::INS_RES8] | ins[adc_pkg::INS_WDOG];
	logic [15:0] corr;
	always_comb begin
		corr = {{3{raw_result[12]}}, raw_result} - offset_coef_q;
		for (int i = 0; i < adc_pkg::N_CAP; i++) begin
			if (!ins_res8 && raw_result[i]) corr = corr - lin_coef_q[i];
		end
	end
	wire [8:0] samp = corr[12:4];
	wire [15:0] lim1 = iram_q[pc_q][31:16];
	wire [15:0] lim2 = iram_q[pc_q][47:32];
	wire hit1 = lim1[adc_pkg::LIM_GT] ? ($signed(samp) > $signed(lim1[8:0]))
		: ($signed(samp) < $signed(lim1[8:0]));
	wire hit2 = lim2[adc_pkg::LIM_GT] ? ($signed(samp) > $signed(lim2[8:0]))
		: ($signed(samp) < $signed(lim2[8:0]));

	// ****************************************************************
	// sequencer and calibration state machine
	// ****************************************************************
	logic [7:0]  tmr_q;
	logic        first_q;
	logic [3:0]  step_q;
	logic [2:0]  rep_q;
	logic [18:0] acc_q;
	logic        res_valid, wd_hit1, wd_hit2, seq_end;
	wire [7:0]  rom_e = adc_pkg::CAL_ROM[{step_q, 3'h0} +: 8];
	wire [7:0]  rom_n = adc_pkg::CAL_ROM[{step_q + 4'h1, 3'h0} +: 8];
	wire [18:0] acc_n = acc_q + {{3{cal_error[15]}}, cal_error};
	wire [15:0] avg   = fc_q ? acc_n[18:3] : acc_n[15:0];
	wire        last_rep = ~fc_q | (rep_q == adc_pkg::CAL_LAST_REP);
	wire [11:0] acq_prod = ins[adc_pkg::INS_ACQ +: 4] * 8'(adc_pkg::ACQ_SPAN);
	wire [7:0]  acq_ld = 8'(adc_pkg::ACQ_MIN_CYC - 1 + acq_prod / adc_pkg::ACQ_STEPS);
	wire        wrap = ins[adc_pkg::INS_LOOP] | (pc_q == 3'h7);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= adc_pkg::ST_IDLE;
			pc_q <= 3'h0;
			tmr_q <= 8'h0;
			first_q <= 1'b1;
			step_q <= 4'h0;
			rep_q <= 3'h0;
			acc_q <= 19'h0;
			offset_coef_q <= 16'h0;
			for (int i = 0; i < adc_pkg::N_CAP; i++) lin_coef_q[i] <= 16'h0;
		end else if (soft_rst) begin
			state_q <= adc_pkg::ST_IDLE;
			pc_q <= 3'h0;
			first_q <= 1'b1;
		end else if (run) begin
			unique case (state_q)
			adc_pkg::ST_IDLE: begin
				if (az_q | fc_q) begin
					state_q <= adc_pkg::ST_CAL;
					step_q <= 4'h0;
					rep_q <= 3'h0;
					acc_q <= 19'h0;
				end else if (start_q) state_q <= adc_pkg::ST_FETCH;
			end
			adc_pkg::ST_FETCH: begin
				// re-arm the skip so the next start runs the paused instruction
				if (ins[adc_pkg::INS_PAUSE] & ~first_q) begin
					state_q <= adc_pkg::ST_IDLE;
					first_q <= 1'b1;
				end else begin
					first_q <= 1'b0;
					tmr_q <= acq_ld;
					state_q <= adc_pkg::ST_ACQ;
				end
			end
			adc_pkg::ST_ACQ: begin
				if (tmr_q != 8'h0) tmr_q <= tmr_q - 8'h1;
				else begin
					tmr_q <= ins_res8 ? 8'(adc_pkg::CONV8_CYC - 1)
						: 8'(adc_pkg::CONV12_CYC - 1);
					state_q <= adc_pkg::ST_CONV;
				end
			end
			adc_pkg::ST_CONV: begin
				if (tmr_q != 8'h0) tmr_q <= tmr_q - 8'h1;
				else begin
					pc_q <= wrap ? 3'h0 : pc_q + 3'h1;
					state_q <= start_q ? adc_pkg::ST_FETCH : adc_pkg::ST_IDLE;
				end
			end
			adc_pkg::ST_CAL: state_q <= adc_pkg::ST_CALW;
			adc_pkg::ST_CALW: begin
				if (cal_error_valid) begin
					rep_q <= rep_q + 3'h1;
					acc_q <= acc_n;
					if (last_rep) begin
						if (rom_e[7:6] == adc_pkg::OP_OFS) offset_coef_q <= avg;
						else lin_coef_q[rom_e[3:0]] <= avg;
						rep_q <= 3'h0;
						acc_q <= 19'h0;
						step_q <= step_q + 4'h1;
						if (~fc_q | (rom_n[7:6] == adc_pkg::OP_END)) state_q <= adc_pkg::ST_IDLE;
						else state_q <= adc_pkg::ST_CAL;
					end else state_q <= adc_pkg::ST_CAL;
				end
			end
			default: state_q <= adc_pkg::ST_IDLE;
			endcase
		end
	end

	// sequencer side effects, decoded from the current state
	wire conv_end = run & ~soft_rst & (state_q == adc_pkg::ST_CONV) & (tmr_q == 8'h0);
	always_comb begin
		pause_clr = run & ~soft_rst & (state_q == adc_pkg::ST_FETCH)
			& ins[adc_pkg::INS_PAUSE] & ~first_q;
		cal_done = run & ~soft_rst & (state_q == adc_pkg::ST_CALW) & cal_error_valid & last_rep
			& (~fc_q | (rom_n[7:6] == adc_pkg::OP_END));
		res_valid = conv_end & ~ins[adc_pkg::INS_WDOG];
		wd_hit1 = conv_end & ins[adc_pkg::INS_WDOG] & hit1;
		wd_hit2 = conv_end & ins[adc_pkg::INS_WDOG] & hit2;
		seq_end = conv_end & wrap;
	end

	// analog-side outputs, registered
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_start <= 1'b0;
			conv_res8 <= 1'b0;
			sample_hold <= 1'b0;
			cal_measure <= 1'b0;
			cal_cap <= 4'h0;
			mux_pos <= 3'h0;
			mux_neg <= 3'h0;
		end else begin
			conv_start <= run & (state_q == adc_pkg::ST_ACQ) & (tmr_q == 8'h0);
			conv_res8 <= ins_res8;
			sample_hold <= (state_q == adc_pkg::ST_ACQ);
			cal_measure <= run & (state_q == adc_pkg::ST_CAL);
			cal_cap <= rom_e[3:0];
			mux_pos <= ins[adc_pkg::INS_POS +: 3];
			mux_neg <= ins[adc_pkg::INS_NEG +: 3];
		end
	end

	// ****************************************************************
	// result fifo, status, interrupt and transfer request
	// ****************************************************************
	logic [15:0] fifo_q [adc_pkg::FIFO_DEPTH];
	logic [4:0]  wr_ptr_q, rd_ptr_q;
	logic [5:0]  fifo_count_q;
	wire fifo_full = (fifo_count_q == 6'(adc_pkg::FIFO_DEPTH));
	wire pop  = acc_rd & ctrl_hit & (reg_sel == adc_pkg::FIFO_OFS) & ~hi & (fifo_count_q != 6'h0)
		& ~bw_q | (acc_rd & ctrl_hit & (reg_sel == adc_pkg::FIFO_OFS) & hi
		& (fifo_count_q != 6'h0));
	wire push = res_valid & ~fifo_full;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 5'h0;
			rd_ptr_q <= 5'h0;
			fifo_count_q <= 6'h0;
			for (int i = 0; i < adc_pkg::FIFO_DEPTH; i++) fifo_q[i] <= 16'h0;
		end else begin
			if (push) begin
				fifo_q[wr_ptr_q] <= corr;
				wr_ptr_q <= wr_ptr_q + 5'h1;
			end
			if (pop) rd_ptr_q <= rd_ptr_q + 5'h1;
			fifo_count_q <= fifo_count_q + {5'h0, push} - {5'h0, pop};
		end
	end

	// events set sticky bits; a status read clears only what it reported, so an
	// event landing while the read waits is kept; a new event wins
	logic [7:0] ev;
	always_comb begin
		ev = 8'h0;
		ev[adc_pkg::INT_LIM1] = wd_hit1;
		ev[adc_pkg::INT_LIM2] = wd_hit2;
		ev[adc_pkg::INT_THR]  = push & (fifo_count_q + 6'h1 == fifo_thr);
		ev[adc_pkg::INT_FULL] = push & (fifo_count_q == 6'(adc_pkg::FIFO_DEPTH - 1));
		ev[adc_pkg::INT_CAL]  = cal_done;
		ev[adc_pkg::INT_PAUS] = pause_clr;
		ev[adc_pkg::INT_END]  = seq_end;
		ev[adc_pkg::INT_OVF]  = res_valid & fifo_full;
	end
	wire stat_rd = acc_rd & ctrl_hit & (reg_sel == adc_pkg::STAT_OFS);
	wire [7:0] stat_d = (stat_rd ? stat_q & ~readdata[7:0] : stat_q) | ev;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stat_q <= 8'h0;
			int_n <= 1'b1;
			transfer_request <= 1'b0;
		end else begin
			stat_q <= stat_d;
			int_n <= ~|(stat_d & inten_q[7:0]);
			if (fifo_count_q == 6'h0) transfer_request <= 1'b0;
			else if (fifo_count_q == fifo_thr) transfer_request <= 1'b1;
		end
	end

	// read data, captured on the first cycle of the request
	logic [15:0] rd16;
	always_comb begin
		rd16 = 16'h0;
		if (iram_hit) rd16 = iram_q[iram_ins][{ptr_q, 4'h0} +: 16];
		else if (ctrl_hit) begin
			if (reg_sel == adc_pkg::CFG_OFS) rd16 = cfg_rd;
			if (reg_sel == adc_pkg::INTEN_OFS) rd16 = inten_q;
			if (reg_sel == adc_pkg::STAT_OFS) rd16 = {8'h0, stat_q};
			if (reg_sel == adc_pkg::FIFO_OFS && fifo_count_q != 6'h0) rd16 = fifo_q[rd_ptr_q];
			if (reg_sel == adc_pkg::CNT_OFS) rd16 = {10'h0, fifo_count_q};
			if (reg_sel == adc_pkg::COEF_OFS) rd16 = offset_coef_q;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) readdata <= 32'h0;
		else if (read & ~ack_q)
			readdata <= bw_q ? {24'h0, hi ? rd16[15:8] : rd16[7:0]} : {16'h0, rd16};
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	localparam int ACQ_MIN = adc_pkg::ACQ_MIN_CYC;
	localparam int ACQ_MAX = adc_pkg::ACQ_MAX_CYC;
	localparam int CONV_HALF = adc_pkg::CONV12_CYC / 2;
	logic [7:0] dwell_q;
	adc_pkg::seq_state_e prev_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dwell_q <= 8'h0;
			prev_q <= adc_pkg::ST_IDLE;
		end else begin
			prev_q <= state_q;
			if (state_q != prev_q) dwell_q <= {7'h0, run}; // a halted first cycle does not count
			else if (run) dwell_q <= dwell_q + 8'h1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	property p_fifo_bound; fifo_count_q <= 6'(adc_pkg::FIFO_DEPTH); endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above 32");
	property p_dreq_low; (fifo_count_q == 6'h0) |=> !transfer_request; endproperty
	a_dreq_low: assert property (p_dreq_low) else $error("request high on empty");
	property p_int_clear;
		(stat_rd && ev == 8'h0 && (stat_q & ~readdata[7:0] & inten_q[7:0]) == 8'h0) |=> int_n;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("interrupt kept after read");
	property p_hold; (!run && !soft_rst) |=> $stable(state_q) && $stable(pc_q); endproperty
	a_hold: assert property (p_hold) else $error("sequencer moved while halted");
	property p_acq_len;
		(state_q == adc_pkg::ST_CONV && prev_q == adc_pkg::ST_ACQ) |->
			dwell_q >= 8'(ACQ_MIN) && dwell_q <= 8'(ACQ_MAX);
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("acquisition time out of range");
	property p_conv_fast;
		(prev_q == adc_pkg::ST_CONV && state_q != adc_pkg::ST_CONV && $past(ins_res8)) |->
			dwell_q < 8'(CONV_HALF);
	endproperty
	a_conv_fast: assert property (p_conv_fast) else $error("8-bit conversion too slow");
	property p_cal_reps; (state_q == adc_pkg::ST_CALW && rep_q != 3'h0) |-> fc_q; endproperty
	a_cal_reps: assert property (p_cal_reps) else $error("repeat in offset-only cal");
	property p_cal_excl;
		(state_q == adc_pkg::ST_CAL || state_q == adc_pkg::ST_CALW) |=> !conv_start [*2];
	endproperty
	a_cal_excl: assert property (p_cal_excl) else $error("conversion during cal");

endmodule

/* File: dv/analog_frontend_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// far-side converter model: sample register and calibration probe
// ****************************************************************
module analog_frontend_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        conv_start,
	input  wire logic        cal_measure,
	input  wire logic [12:0] raw_value,
	input  wire logic [15:0] cal_value,
	output logic      [12:0] raw_result,
	output logic      [15:0] cal_error,
	output logic             cal_error_valid
);
	logic [2:0] wait_q;

	// result freezes at conversion start; before the first one the line holds junk
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			raw_result <= ~raw_value;
		else if (conv_start)
			raw_result <= raw_value;
	end

	// each measurement answers a few cycles later; between answers the bus toggles
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wait_q          <= 3'h0;
			cal_error_valid <= 1'b0;
			cal_error       <= 16'h0000;
		end else begin
			cal_error_valid <= (wait_q == 3'h1);
			cal_error       <= (wait_q == 3'h1) ? cal_value : ~cal_error;
			if (cal_measure)
				wait_q <= 3'h4;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
	end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	localparam logic [6:0]  CFG = adc_pkg::CFG_OFS;
	localparam logic [6:0]  IEN = adc_pkg::INTEN_OFS;
	localparam logic [6:0]  STA = adc_pkg::STAT_OFS;
	localparam logic [6:0]  CNT = adc_pkg::CNT_OFS;
	localparam logic [12:0] RAW = 13'h0123;
	logic        clock, rst, read, write, waitrequest, chip_select_n, bus_width_select;
	logic [6:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic [12:0] raw_result, raw_value;
	logic [15:0] cal_error, cal_value;
	logic        cal_error_valid, conv_start, conv_res8, sample_hold, cal_measure;
	logic [3:0]  cal_cap;
	logic [2:0]  mux_pos, mux_neg;
	logic        diag_route, int_n, transfer_request;
	logic [15:0] sec [3] = '{16'h00ad, 16'h020a, 16'h0264};
	int          fail_count, checks, n_conv, n_cal, sh_w, sh_cnt, gap, cyc, last_cs, conv12;
	int          cap_max;

	adc_sequencer_calibration_control dut (.clock(clock), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .chip_select_n(chip_select_n),
		.bus_width_select(bus_width_select), .raw_result(raw_result), .cal_error(cal_error),
		.cal_error_valid(cal_error_valid), .conv_start(conv_start), .conv_res8(conv_res8),
		.sample_hold(sample_hold), .cal_measure(cal_measure), .cal_cap(cal_cap),
		.mux_pos(mux_pos), .mux_neg(mux_neg), .diag_route(diag_route), .int_n(int_n),
		.transfer_request(transfer_request));
	analog_frontend_model afe (.clock(clock), .rst(rst), .conv_start(conv_start),
		.cal_measure(cal_measure), .raw_value(raw_value), .cal_value(cal_value),
		.raw_result(raw_result), .cal_error(cal_error), .cal_error_valid(cal_error_valid));

	initial clock = 1'b0;
	always #20 clock = ~clock;

	// pulse counts, acquisition width and conversion spacing seen at the ports
	always @(posedge clock) begin
		cyc++;
		if (conv_start) begin
			n_conv++;
			gap = cyc - last_cs;
			last_cs = cyc;
		end
		if (cal_measure) begin
			n_cal++;
			if (cal_cap > cap_max)
				cap_max = cal_cap;
		end
		if (sample_hold)
			sh_cnt++;
		else if (sh_cnt != 0) begin
			sh_w = sh_cnt;
			sh_cnt = 0;
		end
	end

	// ****************************************************************
	// bus access and checking tasks
	// ****************************************************************
	task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= {16'h0000, d};
		read <= ~w;
		write <= w;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			$display("BAD %0t bus hang", $time);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdv(input logic [6:0] a);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (s !== v && n < lim);
		if (n >= lim) begin
			fail_count++;
			$display("BAD %0t wait expired", $time);
		end
	endtask
	// stop, then poll busy so no instruction is cut short
	task automatic stop_seq();
		int n;
		n = 0;
		wr(CFG, 16'h0000);
		do begin
			rdv(CFG);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		chk_bit(rd[0], 1'b0);
	endtask
	task automatic drain(input bit data);
		int n;
		rdv(CNT);
		n = rd;
		repeat (n) begin
			rdv(adc_pkg::FIFO_OFS);
			if (data) chk(rd[12:0], RAW);
		end
		repeat (2) @(posedge clock);
		chk_bit(transfer_request, 1'b0);
		rdv(CNT);
		chk(rd, 32'h0);
	endtask
	task automatic stop_test();
		$display("fail_count %0d checks %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog well beyond the few thousand cycles the sequence needs
	initial begin
		#(60000 * 40);
		fail_count++;
		$display("BAD %0t timeout", $time);
		stop_test();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rst, read, write, address, writedata} = {1'b1, 41'h0};
		{chip_select_n, bus_width_select} = 2'b10;
		{cal_value, raw_value} = {16'h0010, RAW};
		{fail_count, checks, n_conv, n_cal, sh_w, sh_cnt, cyc, last_cs} = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		chk_bit(int_n, 1'b1);
		chk_bit(transfer_request, 1'b0);
		rdv(CNT); chk(rd, 32'h0);
		wr(7'h7c, 16'hffff); rdv(7'h7c); chk(rd, 32'h0);
		wr(IEN, 16'h0210); rdv(IEN); chk(rd, 32'h0210);
		wr(CFG, 16'h0800); @(posedge clock); chk_bit(diag_route, 1'b1);
		wr(CFG, 16'h0000); @(posedge clock); chk_bit(diag_route, 1'b0);
		// in each section the instructions are written last-first, read back in another order
		for (int p = 0; p < 3; p++) begin
			wr(CFG, {6'h00, p[1:0], 8'h00});
			wr(7'h5c, 16'h5a00 + 16'(p)); wr(7'h40, sec[p]);
			rdv(7'h40); chk(rd, {16'h0, sec[p]});
			rdv(7'h5c); chk(rd, {16'h0, 16'h5a00 + 16'(p)});
		end
		wr(CFG, 16'h0300); rdv(7'h40); chk(rd, 32'h0);
		wr(CFG, 16'h0002);
		// offset-only calibration: one measurement, interrupt cleared by status read
		n_cal = 0;
		wr(CFG, 16'h0004); wait_sig(int_n, 1'b0, 3000);
		chk(n_cal, 1);
		rdv(STA); chk_bit(rd[4], 1'b1);
		repeat (2) @(posedge clock); chk_bit(int_n, 1'b1);
		rdv(adc_pkg::COEF_OFS); chk(rd, 32'h10);
		// full calibration: eight per table step, zero error gives zero coefficient
		cal_value <= 16'h0000;
		n_cal = 0;
		wr(CFG, 16'h0008); wait_sig(int_n, 1'b0, 5000);
		chk(n_cal, 8 * (1 + 13));
		chk(cap_max, adc_pkg::N_CAP - 1);
		rdv(STA); chk_bit(rd[4], 1'b1);
		rdv(adc_pkg::COEF_OFS); chk(rd, 32'h0);
		// 12-bit conversions with shortest acquisition
		wr(CFG, 16'h0001); wait_sig(transfer_request, 1'b1, 2000);
		rdv(CNT); chk(rd, 32'h2);
		chk(mux_pos, 3'h3); chk(mux_neg, 3'h5);
		chk_bit(conv_res8, 1'b0); chk(sh_w, adc_pkg::ACQ_MIN_CYC);
		conv12 = gap - sh_w;
		// chip select low must freeze conversions; the pin syncs in two edges
		chip_select_n <= 1'b0;
		repeat (4) @(posedge clock);
		n_conv = 0;
		repeat (400) @(posedge clock);
		chk(n_conv, 0);
		chip_select_n <= 1'b1; wait_sig(conv_start, 1'b1, 400);
		stop_seq(); drain(1'b1);
		// 8-bit conversions with longest acquisition
		wr(CFG, 16'h0000); wr(7'h40, 16'hf4ad); wr(CFG, 16'h0002);
		wr(CFG, 16'h0001);
		repeat (3) wait_sig(conv_start, 1'b1, 600);
		chk_bit(conv_res8, 1'b1); chk(sh_w, adc_pkg::ACQ_MAX_CYC);
		chk_bit((gap - sh_w) * 2 < conv12, 1'b1);
		stop_seq(); drain(1'b0);
		// window compare: sample above limit one only, nothing stored
		wr(7'h40, 16'h08ad); wr(IEN, 16'h0501); wr(CFG, 16'h0002);
		rdv(STA);
		wr(CFG, 16'h0001); wait_sig(int_n, 1'b0, 2000);
		rdv(STA); chk({30'h0, rd[1:0]}, 32'h1);
		stop_seq(); rdv(CNT); chk(rd, 32'h0);
		// pause: skipped on the first fetch, stops the second, runs again on start
		wr(7'h40, 16'h00af); wr(CFG, 16'h0002); rdv(STA);
		wr(CFG, 16'h0001); wait_sig(conv_start, 1'b1, 400);
		repeat (300) @(posedge clock);
		rdv(STA); chk_bit(rd[5], 1'b1); rdv(CFG); chk_bit(rd[0], 1'b0);
		wr(CFG, 16'h0001); wait_sig(conv_start, 1'b1, 400);
		stop_seq(); drain(1'b1);
		// 8-bit bus: byte lanes of the enable register
		bus_width_select <= 1'b1;
		repeat (3) @(posedge clock);
		rdv(IEN); chk(rd, 32'h01);
		rdv(IEN | 7'h04); chk(rd, 32'h05);
		bus_width_select <= 1'b0;
		stop_test();
	end
endmodule
